//--- design/tsc_pkg.sv
// ***********************************************************************
// Capture unit shared constants
// ***********************************************************************
package tsc_pkg;

   // ********************************************************************
   // Register byte offsets
   // ********************************************************************
   localparam logic [7:0] TSC_REG_CFG      = 8'h00;  // Source, edge, auto arm
   localparam logic [7:0] TSC_REG_PERIOD   = 8'h04;  // Sampling cycle, clocks minus one
   localparam logic [7:0] TSC_REG_TOTAL    = 8'h08;  // Total sample count
   localparam logic [7:0] TSC_REG_PRE      = 8'h0C;  // Pre-trigger sample count
   localparam logic [7:0] TSC_REG_COMMIT   = 8'h10;  // Store / erase command
   localparam logic [7:0] TSC_REG_ARM      = 8'h14;  // capture_arm_request_word
   localparam logic [7:0] TSC_REG_DISARM   = 8'h18;  // capture_disarm_request_word
   localparam logic [7:0] TSC_REG_STATUS   = 8'h1C;  // Execution state
   localparam logic [7:0] TSC_REG_IRQ_STAT = 8'h20;  // Sticky events, read clears
   localparam logic [7:0] TSC_REG_IRQ_MASK = 8'h24;  // Interrupt enables
   localparam logic [7:0] TSC_REG_RD_PTR   = 8'h28;  // Sample readout index
   localparam logic [7:0] TSC_REG_RD_DATA  = 8'h2C;  // Sample readout, auto increment

   // ********************************************************************
   // Field positions
   // ********************************************************************
   localparam int unsigned TSC_CFG_KIND_BIT = 0;   // 0 external input, 1 counter
   localparam int unsigned TSC_CFG_IDX_LSB  = 1;   // Source index, 4 bits
   localparam int unsigned TSC_CFG_IDX_W    = 4;
   localparam int unsigned TSC_CFG_EDGE_BIT = 5;   // 0 rising, 1 falling
   localparam int unsigned TSC_CFG_AUTO_BIT = 6;   // Auto arm on logic start
   localparam int unsigned TSC_CFG_W        = 7;
   localparam int unsigned TSC_CMD_EXEC_BIT  = 0;  // Store to execution memory
   localparam int unsigned TSC_CMD_FLASH_BIT = 1;  // Also store to flash
   localparam int unsigned TSC_CMD_ERASE_BIT = 2;  // Erase stored setting
   localparam int unsigned TSC_REQ_BIT       = 0;  // Request words act on a 1
   localparam int unsigned TSC_IRQ_TRIG_BIT  = 0;  // Trigger seen
   localparam int unsigned TSC_IRQ_DONE_BIT  = 1;  // Collection complete
   localparam int unsigned TSC_IRQ_W         = 2;
   localparam int unsigned TSC_ST_DONE_BIT   = 4;  // Status: complete flag
   localparam int unsigned TSC_ST_COUNT_LSB  = 16; // Status: samples held
   localparam int unsigned TSC_NUM_W         = 16; // Width of count fields
   localparam int unsigned TSC_IMG_W         = 55; // Flash image width

   // ********************************************************************
   // Reset values
   // ********************************************************************
   localparam logic [TSC_CFG_W-1:0] TSC_CFG_RST    = 7'h00;
   localparam logic [TSC_NUM_W-1:0] TSC_PERIOD_RST = 16'h0000;
   localparam logic [TSC_NUM_W-1:0] TSC_TOTAL_RST  = 16'h0400;
   localparam logic [TSC_NUM_W-1:0] TSC_PRE_RST    = 16'h0000;

   // ********************************************************************
   // Execution states
   // ********************************************************************
   typedef enum logic [3:0] {
      TSC_STOP  = 4'h1,  // Trigger stopped, nothing held
      TSC_ARMED = 4'h2,  // Trigger ready, ring filling
      TSC_POST  = 4'h4,  // Triggered, taking post samples
      TSC_DONE  = 4'h8   // Data collection complete
   } tsc_state_t;

endpackage : tsc_pkg

//--- design/tsc_edge_det.sv
`timescale 1ns/1ps
// ***********************************************************************
// Edge detector for the selected trigger source
// ***********************************************************************
module tsc_edge_det (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic level,     // Selected source level
   input  wire logic fall_sel,  // 1 picks the falling edge
   output logic      pulse      // One cycle on the chosen edge
);
   logic prev_q;   // Level one cycle ago
   logic valid_q;  // Blocks a false edge right after reset

   // Previous level and validity
   always_ff @(posedge clk) begin
      if (reset) begin
         prev_q  <= 1'b0;
         valid_q <= 1'b0;
      end else begin
         prev_q  <= level;
         valid_q <= 1'b1;
      end
   end

   // Rise or fall selection
   always_comb begin
      if (fall_sel) begin
         pulse = valid_q & prev_q & ~level;
      end else begin
         pulse = valid_q & ~prev_q & level;
      end
   end
endmodule : tsc_edge_det

//--- design/tsc_sample_ram.sv
`timescale 1ns/1ps
// ***********************************************************************
// Sample store, one write port and one combinational read port
// ***********************************************************************
module tsc_sample_ram #(
   parameter int unsigned W  = 16,  // Sample width
   parameter int unsigned AW = 10   // Address width
) (
   input  wire logic          clk,
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [W-1:0]  wr_data,
   input  wire logic [AW-1:0] rd_addr,
   output logic      [W-1:0]  rd_data
);
   logic [W-1:0] mem [0:(1<<AW)-1];  // No reset: contents valid only after capture

   // Write side
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Read side, registered by the caller
   assign rd_data = mem[rd_addr];
endmodule : tsc_sample_ram

//--- design/tsc_capture_top.sv
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module tsc_capture_top import tsc_pkg::*; #(
   parameter int unsigned SAMPLE_W = 16,  // Monitored signal count
   parameter int unsigned ADDR_W   = 10,  // Ring depth is 2**ADDR_W, at most 15
   parameter int unsigned EXT_N    = 12,  // External input blocks
   parameter int unsigned CNT_N    = 2    // Counter block outputs
) (
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [31:0]          reg_rdata_q,
   output logic                      irq_q,
   input  wire logic [EXT_N-1:0]     ext_in_pin,
   input  wire logic [CNT_N-1:0]     counter_out,
   input  wire logic [SAMPLE_W-1:0]  probe_pin,
   input  wire logic                 logic_run,
   output logic                      flash_save_q,
   output logic                      flash_erase_q,
   output logic      [TSC_IMG_W-1:0] flash_image_q,
   input  wire logic                 flash_load,
   input  wire logic [TSC_IMG_W-1:0] flash_image
);
   localparam int unsigned CW = ADDR_W + 1;                   // Count width
   localparam logic [CW-1:0] DEPTH = CW'(1 << ADDR_W);        // Ring size

   // ********************************************************************
   // Helpers
   // ********************************************************************
   // Limit a 16-bit count to a ceiling
   function automatic logic [CW-1:0] clamp_cnt(input logic [TSC_NUM_W-1:0] v,
                                               input logic [CW-1:0] lim);
      logic [TSC_NUM_W-1:0] l16;
      l16 = TSC_NUM_W'(lim);
      clamp_cnt = (v > l16) ? lim : CW'(v);
   endfunction : clamp_cnt

   // Smaller of two counts
   function automatic logic [CW-1:0] min_cnt(input logic [CW-1:0] a,
                                             input logic [CW-1:0] b);
      min_cnt = (a < b) ? a : b;
   endfunction : min_cnt

   // ********************************************************************
   // Declarations
   // ********************************************************************
   logic [EXT_N-1:0]     ext_meta_q, ext_sync_q;       // Pin synchroniser
   logic [SAMPLE_W-1:0]  probe_meta_q, probe_sync_q;   // Probe synchroniser
   logic [TSC_CFG_W-1:0] stg_cfg_q, ex_cfg_q;          // Staged and active setting
   logic [TSC_NUM_W-1:0] stg_period_q, ex_period_q;
   logic [TSC_NUM_W-1:0] stg_total_q, stg_pre_q;
   logic [CW-1:0]        ex_total_q, ex_pre_q;
   tsc_state_t           state_q, state_d;             // Execution state
   logic                 run_q;                        // Logic control, last cycle
   logic [TSC_NUM_W-1:0] per_cnt_q;                    // Sampling period counter
   logic [ADDR_W-1:0]    wp_q, wp_d;                   // Ring write pointer
   logic [CW-1:0]        fill_q, fill_d;               // Valid history in ring
   logic [CW-1:0]        post_left_q;                  // Post samples still due
   logic [CW-1:0]        pre_have_q, pre_have_d;       // Pre samples kept
   logic [ADDR_W-1:0]    start_q;                      // Oldest captured sample
   logic [CW-1:0]        count_q;                      // Samples captured
   logic [ADDR_W-1:0]    rd_ptr_q;                     // Readout index
   logic [TSC_IRQ_W-1:0] irq_st_q, irq_st_d, irq_mask_q;
   logic [SAMPLE_W-1:0]  ram_rd;
   logic [TSC_IRQ_W-1:0] irq_ev;
   logic                 src_level, trig, sampling, tick, done_go, arm_go, stop_go;
   logic                 wr_commit, do_store, do_erase, arm_req, disarm_req;
   logic                 run_rise, run_fall;
   logic [CW-1:0]        post_cnt;

   // ********************************************************************
   // Input synchronisers
   // ********************************************************************
   // Two flops on every pin before use
   always_ff @(posedge clk) begin
      if (reset) begin
         ext_meta_q   <= '0;
         ext_sync_q   <= '0;
         probe_meta_q <= '0;
         probe_sync_q <= '0;
      end else begin
         ext_meta_q   <= ext_in_pin;
         ext_sync_q   <= ext_meta_q;
         probe_meta_q <= probe_pin;
         probe_sync_q <= probe_meta_q;
      end
   end

   // ********************************************************************
   // Register decode
   // ********************************************************************
   assign wr_commit  = reg_wr && (reg_addr == TSC_REG_COMMIT);
   assign do_store   = wr_commit && reg_wdata[TSC_CMD_EXEC_BIT];
   assign do_erase   = wr_commit && reg_wdata[TSC_CMD_ERASE_BIT];
   assign arm_req    = reg_wr && (reg_addr == TSC_REG_ARM)
                       && reg_wdata[TSC_REQ_BIT];
   assign disarm_req = reg_wr && (reg_addr == TSC_REG_DISARM)
                       && reg_wdata[TSC_REQ_BIT];
   assign run_rise   = logic_run & ~run_q;
   assign run_fall   = ~logic_run & run_q;

   // Staged setting, written by software
   always_ff @(posedge clk) begin
      if (reset) begin
         stg_cfg_q    <= TSC_CFG_RST;
         stg_period_q <= TSC_PERIOD_RST;
         stg_total_q  <= TSC_TOTAL_RST;
         stg_pre_q    <= TSC_PRE_RST;
      end else if (reg_wr) begin
         if (reg_addr == TSC_REG_CFG)    stg_cfg_q    <= reg_wdata[TSC_CFG_W-1:0];
         if (reg_addr == TSC_REG_PERIOD) stg_period_q <= reg_wdata[TSC_NUM_W-1:0];
         if (reg_addr == TSC_REG_TOTAL)  stg_total_q  <= reg_wdata[TSC_NUM_W-1:0];
         if (reg_addr == TSC_REG_PRE)    stg_pre_q    <= reg_wdata[TSC_NUM_W-1:0];
      end
   end

   // Active setting; pre is clamped to total so software cannot overrun
   always_ff @(posedge clk) begin
      if (reset || do_erase) begin
         ex_cfg_q    <= TSC_CFG_RST;
         ex_period_q <= TSC_PERIOD_RST;
         ex_total_q  <= clamp_cnt(TSC_TOTAL_RST, DEPTH);
         ex_pre_q    <= TSC_PRE_RST[CW-1:0];
      end else if (do_store) begin
         ex_cfg_q    <= stg_cfg_q;
         ex_period_q <= stg_period_q;
         ex_total_q  <= clamp_cnt(stg_total_q, DEPTH);
         ex_pre_q    <= clamp_cnt(stg_pre_q, clamp_cnt(stg_total_q, DEPTH));
      end else if (flash_load) begin
         ex_cfg_q    <= flash_image[54:48];
         ex_period_q <= flash_image[47:32];
         ex_total_q  <= clamp_cnt(flash_image[31:16], DEPTH);
         ex_pre_q    <= clamp_cnt(flash_image[15:0],
                                  clamp_cnt(flash_image[31:16], DEPTH));
      end
   end

   // Flash strobes, one cycle each
   always_ff @(posedge clk) begin
      if (reset) begin
         flash_save_q  <= 1'b0;
         flash_erase_q <= 1'b0;
         flash_image_q <= '0;
      end else begin
         flash_save_q  <= do_store && reg_wdata[TSC_CMD_FLASH_BIT];
         flash_erase_q <= do_erase;
         if (do_store) begin
            flash_image_q <= {stg_cfg_q, stg_period_q, stg_total_q, stg_pre_q};
         end
      end
   end

   // ********************************************************************
   // Trigger source and edge
   // ********************************************************************
   // Out-of-range index reads as low
   always_comb begin
      src_level = 1'b0;
      if (ex_cfg_q[TSC_CFG_KIND_BIT]) begin
         for (int i = 0; i < CNT_N; i++) begin
            if (ex_cfg_q[TSC_CFG_IDX_LSB +: TSC_CFG_IDX_W] == TSC_CFG_IDX_W'(i)) begin
               src_level = counter_out[i];
            end
         end
      end else begin
         for (int i = 0; i < EXT_N; i++) begin
            if (ex_cfg_q[TSC_CFG_IDX_LSB +: TSC_CFG_IDX_W] == TSC_CFG_IDX_W'(i)) begin
               src_level = ext_sync_q[i];
            end
         end
      end
   end

   tsc_edge_det u_edge (
      .clk      (clk),
      .reset    (reset),
      .level    (src_level),
      .fall_sel (ex_cfg_q[TSC_CFG_EDGE_BIT]),
      .pulse    (trig)
   );

   // ********************************************************************
   // Execution state machine
   // ********************************************************************
   assign sampling = (state_q == TSC_ARMED) || (state_q == TSC_POST);
   assign stop_go  = disarm_req || do_store || do_erase || run_fall;
   assign arm_go   = arm_req || (run_rise && ex_cfg_q[TSC_CFG_AUTO_BIT]);
   assign post_cnt = ex_total_q - ex_pre_q;
   assign done_go  = sampling && !stop_go
                     && (trig ? (post_cnt == '0)
                              : (state_q == TSC_POST && tick && post_left_q == CW'(1)));

   // Next state
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         TSC_STOP, TSC_DONE: begin
            if (arm_go) state_d = TSC_ARMED;
         end
         TSC_ARMED, TSC_POST: begin
            if (stop_go) begin
               state_d = TSC_STOP;
            end else if (done_go) begin
               state_d = TSC_DONE;
            end else if (trig) begin
               state_d = TSC_POST;
            end
         end
         default: state_d = TSC_STOP;
      endcase
   end

   // State and logic-run history; a later restart re-arms by itself only with auto arm set
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= TSC_STOP;
         run_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         run_q   <= logic_run;
      end
   end

   // ********************************************************************
   // Sampling and ring buffer
   // ********************************************************************
   assign tick   = sampling && (per_cnt_q >= ex_period_q);
   assign wp_d   = tick ? wp_q + ADDR_W'(1) : wp_q;
   assign fill_d = (tick && fill_q != DEPTH) ? fill_q + CW'(1) : fill_q;
   assign pre_have_d = (sampling && trig) ? min_cnt(fill_d, ex_pre_q)
                                          : pre_have_q;

   // Period counter, restarted on arming
   always_ff @(posedge clk) begin
      if (reset || !sampling || tick) begin
         per_cnt_q <= '0;
      end else begin
         per_cnt_q <= per_cnt_q + TSC_NUM_W'(1);
      end
   end

   // Ring write position and history depth
   always_ff @(posedge clk) begin
      if (reset) begin
         wp_q   <= '0;
         fill_q <= '0;
      end else if (!sampling && arm_go) begin
         fill_q <= '0;                                                       // History starts fresh
      end else begin
         wp_q   <= wp_d;
         fill_q <= fill_d;
      end
   end

   // Post count, reloaded by every trigger
   always_ff @(posedge clk) begin
      if (reset) begin
         post_left_q <= '0;
         pre_have_q  <= '0;
      end else if (sampling && trig) begin
         post_left_q <= post_cnt;
         pre_have_q  <= pre_have_d;
      end else if (state_q == TSC_POST && tick) begin
         post_left_q <= post_left_q - CW'(1);
      end
   end

   // Capture window fixed at completion
   always_ff @(posedge clk) begin
      if (reset) begin
         start_q <= '0;
         count_q <= '0;
      end else if (done_go) begin
         count_q <= pre_have_d + post_cnt;
         start_q <= wp_d - ADDR_W'(pre_have_d + post_cnt);
      end
   end

   tsc_sample_ram #(
      .W  (SAMPLE_W),
      .AW (ADDR_W)
   ) u_ram (
      .clk     (clk),
      .wr_en   (tick),
      .wr_addr (wp_q),
      .wr_data (probe_sync_q),
      .rd_addr (start_q + rd_ptr_q),
      .rd_data (ram_rd)
   );

   // ********************************************************************
   // Interrupts
   // ********************************************************************
   assign irq_ev[TSC_IRQ_TRIG_BIT] = sampling && trig && !stop_go;
   assign irq_ev[TSC_IRQ_DONE_BIT] = done_go;
   // Event in the clearing read survives
   assign irq_st_d = ((reg_rd && reg_addr == TSC_REG_IRQ_STAT) ? '0 : irq_st_q) | irq_ev;

   // Sticky status, mask, level output
   always_ff @(posedge clk) begin
      if (reset) begin
         irq_st_q   <= '0;
         irq_mask_q <= '0;
         irq_q      <= 1'b0;
      end else begin
         irq_st_q <= irq_st_d;
         if (reg_wr && reg_addr == TSC_REG_IRQ_MASK) begin
            irq_mask_q <= reg_wdata[TSC_IRQ_W-1:0];
         end
         irq_q <= |(irq_st_d & irq_mask_q);
      end
   end

   // ********************************************************************
   // Readout
   // ********************************************************************
   // Pointer set by software, stepped by each data read
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_ptr_q <= '0;
      end else if (reg_wr && reg_addr == TSC_REG_RD_PTR) begin
         rd_ptr_q <= reg_wdata[ADDR_W-1:0];
      end else if (reg_rd && reg_addr == TSC_REG_RD_DATA) begin
         rd_ptr_q <= rd_ptr_q + ADDR_W'(1);
      end
   end

   // Read data, valid only the cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset || !reg_rd) begin
         reg_rdata_q <= '0;
      end else begin
         unique case (reg_addr)
            TSC_REG_CFG:      reg_rdata_q <= 32'(ex_cfg_q);
            TSC_REG_PERIOD:   reg_rdata_q <= 32'(ex_period_q);
            TSC_REG_TOTAL:    reg_rdata_q <= 32'(ex_total_q);
            TSC_REG_PRE:      reg_rdata_q <= 32'(ex_pre_q);
            TSC_REG_STATUS:   reg_rdata_q <= (32'(count_q) << TSC_ST_COUNT_LSB)
                                             | (32'(state_q == TSC_DONE) << TSC_ST_DONE_BIT)
                                             | 32'(state_q);
            TSC_REG_IRQ_STAT: reg_rdata_q <= 32'(irq_st_q);
            TSC_REG_IRQ_MASK: reg_rdata_q <= 32'(irq_mask_q);
            TSC_REG_RD_PTR:   reg_rdata_q <= 32'(rd_ptr_q);
            TSC_REG_RD_DATA:  reg_rdata_q <= (state_q == TSC_DONE)
                                             ? 32'(ram_rd) : 32'h0000_0000;
            default:          reg_rdata_q <= 32'h0000_0000;                  // Unmapped
         endcase
      end
   end
endmodule : tsc_capture_top

//--- verif/tsc_capture_assertions.sv
`timescale 1ns/1ps
// ****************************************************************
// Port checks for the capture unit
// ****************************************************************
module tsc_capture_assertions import tsc_pkg::*; (
   input wire logic        clk,
   input wire logic        reset,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata_q,
   input wire logic        irq_q,
   input wire logic        flash_save_q,
   input wire logic        flash_erase_q
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   // Commit writes that reach the flash
   sequence s_save;
      reg_wr && reg_addr == TSC_REG_COMMIT && reg_wdata[1:0] == 2'h3;
   endsequence
   sequence s_erase;
      reg_wr && reg_addr == TSC_REG_COMMIT && reg_wdata[2];
   endsequence
   AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata_q == 32'h0)
      else $error("read data outside its slot");
   AST_SAVE: assert property (s_save |=> flash_save_q)
      else $error("flash store missing");
   AST_SAVE_ONE: assert property (flash_save_q |=> !flash_save_q)
      else $error("flash store too long");
   AST_SAVE_WHY: assert property (flash_save_q |-> $past(reg_wr && reg_wdata[1]))
      else $error("flash store without command");
   AST_ERASE: assert property (s_erase |=> flash_erase_q)
      else $error("erase pulse missing");
   AST_ERASE_ONE: assert property (flash_erase_q |=> !flash_erase_q)
      else $error("erase pulse too long");
   AST_UNMAPPED: assert property (reg_rd && reg_addr == 8'h30 |=> reg_rdata_q == 32'h0)
      else $error("unmapped read not zero");
   AST_STATE_HOT: assert property (reg_rd && reg_addr == TSC_REG_STATUS |=>
      $onehot(reg_rdata_q[3:0]))
      else $error("state field not one-hot");
   // Mask cleared means the line must drop soon
   AST_MASK_OFF: assert property (reg_wr && reg_addr == TSC_REG_IRQ_MASK &&
      reg_wdata[1:0] == 2'h0 |-> ##[1:2] !irq_q)
      else $error("interrupt stays up when masked");
endmodule : tsc_capture_assertions
bind tsc_capture_top tsc_capture_assertions u_ast (.clk, .reset, .reg_addr, .reg_wdata,
   .reg_wr, .reg_rd, .reg_rdata_q, .irq_q, .flash_save_q, .flash_erase_q);

//--- verif/tsc_src_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Far side: counter trigger source and probed states
// ****************************************************************
module tsc_src_model (
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        trig,         // Level asked for by the bench
   output logic      [1:0]  counter_out,
   output logic      [15:0] probe_pin
);
   // Only counter 0 toggles, so a wrong index shows as no trigger
   assign counter_out = {1'b0, trig};
   // Changes every cycle, so sample order is visible
   always_ff @(posedge clk) begin
      if (reset) probe_pin <= 16'h0000;
      else probe_pin <= probe_pin + 16'h0001;
   end
endmodule : tsc_src_model

//--- verif/tb.sv
`timescale 1ns/1ps
module tb import tsc_pkg::*; ;
   logic        clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic        logic_run = 1'b0, trig = 1'b0, irq_q, flash_save_q, flash_erase_q;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata_q, q;
   logic [1:0]  counter_out;
   logic [15:0] probe_pin, s;
   logic [TSC_IMG_W-1:0] flash_image_q, flash_store = '0;
   logic        flash_load = 1'b0;
   int          n_fail = 0, comparisons = 0;
   tsc_capture_top DUT (.clk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q,
      .irq_q, .ext_in_pin({11'h000, trig}), .counter_out, .probe_pin, .logic_run, .flash_save_q,
      .flash_erase_q, .flash_image_q, .flash_load, .flash_image(flash_store));
   tsc_src_model u_src (.clk, .reset, .trig, .counter_out, .probe_pin);
   // Far-side flash: keeps the image only on a store pulse
   always @(posedge clk) if (flash_save_q) flash_store <= flash_image_q;
   initial forever #4 clk = ~clk;
   // Hang guard
   initial begin
      repeat (5000) @(posedge clk);
      n_fail++;
      report_and_stop();
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk) begin reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; end
      @(posedge clk) reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk) begin reg_addr <= a; reg_rd <= 1'b1; end
      @(posedge clk) reg_rd <= 1'b0;
      #1 q = reg_rdata_q;
   endtask : rd
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      comparisons++;
      if (g !== e) begin n_fail++; $display("BAD %0t got %h want %h", $time, g, e); end
   endtask : chk
   task automatic st(input logic [31:0] e);
      rd(TSC_REG_STATUS);
      chk({27'h0, q[4:0]}, e);
   endtask : st
   task automatic t_reset();
      rd(TSC_REG_CFG); chk(q, 32'h0);
      rd(TSC_REG_TOTAL); chk(q, 32'h400);
      rd(TSC_REG_PRE); chk(q, 32'h0);
      rd(8'h30); chk(q, 32'h0);
      st(32'h01);
   endtask : t_reset
   // Capture of four, two before the chosen edge; rise from counter 0, fall from pin 0
   task automatic t_cap(input logic fall);
      @(posedge clk) trig <= fall;
      wr(TSC_REG_CFG, {26'h0, fall, 4'h0, ~fall}); wr(TSC_REG_TOTAL, 32'h4);
      wr(TSC_REG_PRE, 32'h2); wr(TSC_REG_PERIOD, 32'h0); wr(TSC_REG_COMMIT, 32'h1);
      wr(TSC_REG_IRQ_MASK, 32'h2); wr(TSC_REG_ARM, 32'h1);
      st(32'h02);
      @(posedge clk) trig <= ~fall;
      for (int i = 0; i < 20 && q[3] !== 1'b1; i++) rd(TSC_REG_STATUS);
      chk(q, 32'h00040018);
      chk({31'h0, irq_q}, 32'h1);
      wr(TSC_REG_IRQ_MASK, 32'h0);
      @(posedge clk) #1 chk({31'h0, irq_q}, 32'h0);
      rd(TSC_REG_IRQ_STAT); chk(q, 32'h3);
      rd(TSC_REG_IRQ_STAT); chk(q, 32'h0);
      wr(TSC_REG_RD_PTR, 32'h0); rd(TSC_REG_RD_DATA); s = q[15:0];
      for (int i = 1; i < 4; i++) begin rd(TSC_REG_RD_DATA); chk(q, {16'h0, s + 16'(i)}); end
   endtask : t_cap
   // Second edge during post sampling restarts the post count
   task automatic t_retrig();
      wr(TSC_REG_CFG, 32'h01); wr(TSC_REG_TOTAL, 32'h8); wr(TSC_REG_PRE, 32'h0);
      wr(TSC_REG_COMMIT, 32'h1); wr(TSC_REG_ARM, 32'h1);
      @(posedge clk) trig <= 1'b1;
      repeat (4) @(posedge clk);
      trig <= 1'b0;
      @(posedge clk) trig <= 1'b1;
      repeat (3) @(posedge clk);
      st(32'h04);
      for (int i = 0; i < 20 && q[3] !== 1'b1; i++) rd(TSC_REG_STATUS);
      chk(q, 32'h00080018);
   endtask : t_retrig
   // Auto arm, logic stop, requests, flash store and restore, erase
   task automatic t_run();
      wr(TSC_REG_CFG, 32'h41); wr(TSC_REG_COMMIT, 32'h3);
      #1 chk({9'h0, flash_image_q[54:32]}, 32'h0041_0000);
      chk(flash_image_q[31:0], 32'h0008_0000);
      @(posedge clk) logic_run <= 1'b1;
      st(32'h02);
      @(posedge clk) logic_run <= 1'b0;
      st(32'h01);
      wr(TSC_REG_ARM, 32'h0); st(32'h01);
      wr(TSC_REG_ARM, 32'h1); st(32'h02);
      wr(TSC_REG_DISARM, 32'h1); st(32'h01);
      wr(TSC_REG_CFG, 32'h0); wr(TSC_REG_COMMIT, 32'h1);
      rd(TSC_REG_CFG); chk(q, 32'h0);
      @(posedge clk) flash_load <= 1'b1;
      @(posedge clk) flash_load <= 1'b0;
      rd(TSC_REG_CFG); chk(q, 32'h41);
      wr(TSC_REG_COMMIT, 32'h4); rd(TSC_REG_CFG); chk(q, 32'h0);
      wr(TSC_REG_ARM, 32'h1);
      @(posedge clk) logic_run <= 1'b1;
      @(posedge clk) logic_run <= 1'b0;
      @(posedge clk) logic_run <= 1'b1;
      st(32'h01);
      @(posedge clk) logic_run <= 1'b0;
      wr(TSC_REG_IRQ_MASK, 32'h0);
   endtask : t_run
   task automatic report_and_stop();
      if (n_fail == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (10) @(posedge clk);
      reset <= 1'b0;
      t_reset(); t_cap(1'b0); t_cap(1'b1); t_retrig(); t_run();
      report_and_stop();
   end
endmodule : tb
